// >>> design/slcr_k_calc.sv
// Effective frames per multiframe for the selected line coding
`timescale 1ns/1ps
module slcr_k_calc #(
   parameter int unsigned KW = slcr_pkg::K_W,
   parameter int unsigned EW = slcr_pkg::E_W,
   parameter int unsigned FW = slcr_pkg::F_W
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_rstn,
   input  wire logic                       i_is_64b66b,
   input  wire logic [slcr_pkg::KM1_W-1:0] i_km1,
   input  wire logic [EW-1:0]              i_e,
   input  wire logic [FW-1:0]              i_f,
   output      logic [KW-1:0]              o_k_q
);

   logic [KW-1:0] num;
   logic [KW-1:0] den;
   logic [KW-1:0] k_d;

   always_comb
   begin
      num = KW'({i_e, {slcr_pkg::K66_SHIFT{1'b0}}});
      // A zero F would divide by zero; it is treated as one
      den = (i_f == '0) ? KW'(1) : KW'(i_f);
      if (i_is_64b66b)
         k_d = num / den;
      else
         k_d = KW'(i_km1) + KW'(1);
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_k_q <= KW'(slcr_pkg::RST_KM1) + KW'(1);
      else
         o_k_q <= k_d;
   end

endmodule

// >>> design/slcr_pin_filter.sv
// Three-stage synchroniser for asynchronous pins, updating when stages two and three agree
`timescale 1ns/1ps
module slcr_pin_filter #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_pin,
   output      logic [WIDTH-1:0] o_level_q
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end
      else
      begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Only stages two and three are compared; stage one may be metastable
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         always_ff @(posedge i_clk or negedge i_rstn)
         begin
            if (!i_rstn)
               o_level_q[g] <= RESET_VAL[g];
            else if (s2_q[g] == s3_q[g])
               o_level_q[g] <= s3_q[g];
         end
      end
   endgenerate

endmodule

// >>> design/slcr_pkg.sv
// Shared constants for the serial link configuration register bank
package slcr_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 8;

   // Register offsets (byte addresses on the plain register port)
   localparam logic [ADDR_W-1:0] ADDR_LINK_ENABLE   = 10'h200;
   localparam logic [ADDR_W-1:0] ADDR_OUTPUT_MODE   = 10'h201;
   localparam logic [ADDR_W-1:0] ADDR_FRAMES_PER_MF = 10'h202;
   localparam logic [ADDR_W-1:0] ADDR_SOFT_SYNC     = 10'h203;
   localparam logic [ADDR_W-1:0] ADDR_LINK_CONTROL  = 10'h204;
   localparam logic [ADDR_W-1:0] ADDR_TEST_CONTROL  = 10'h205;

   // Field widths
   localparam int unsigned MODE_W  = 6;
   localparam int unsigned KM1_W   = 8;
   localparam int unsigned TEST_W  = 5;
   localparam int unsigned SSEL_W  = 2;

   // Field positions inside the link control register
   localparam int unsigned CTRL_WHITEN_BIT = 0;
   localparam int unsigned CTRL_FORMAT_BIT = 1;
   localparam int unsigned CTRL_SSEL_LSB   = 2;
   localparam int unsigned CTRL_UPPER_BIT  = 4;

   // Reset values
   localparam logic              RST_LINK_ENABLE = 1'b1;
   localparam logic [MODE_W-1:0] RST_OUTPUT_MODE = 6'h00;
   localparam logic [KM1_W-1:0]  RST_KM1         = 8'h1F;
   localparam logic              RST_SOFT_SYNC_N = 1'b1;
   localparam logic [7:0]        RST_LINK_CTRL   = 8'h03;
   localparam logic [TEST_W-1:0] RST_TEST_CTRL   = 5'h00;

   // Sync source selections
   localparam logic [SSEL_W-1:0] SSEL_SINGLE_ENDED = 2'h0;
   localparam logic [SSEL_W-1:0] SSEL_TIMESTAMP    = 2'h1;
   localparam logic [SSEL_W-1:0] SSEL_SOFTWARE     = 2'h2;

   // Lane geometry and multiframe scaling
   localparam int unsigned LANES       = 8;
   localparam int unsigned UPPER_BASE  = 4;
   localparam int unsigned LCNT_W      = 4;
   localparam int unsigned K_W         = 12;
   localparam int unsigned E_W         = 3;
   localparam int unsigned F_W         = 5;
   localparam int unsigned K66_SHIFT   = 8;

   // Cycles the gated clocks run before the link leaves reset
   localparam int unsigned CLK_SETTLE_CYCLES = 4;
   localparam int unsigned SETTLE_W          = 4;

   typedef enum logic [1:0] {
      SLCR_OFF    = 2'b00,
      SLCR_CLK_ON = 2'b01,
      SLCR_RUN    = 2'b11
   } slcr_state_e;

endpackage

// >>> design/slcr_serial_link_config_regs.sv
// Serial link configuration registers, sync request logic and link enable sequencing
`timescale 1ns/1ps
module slcr_serial_link_config_regs #(
   parameter int unsigned LANES  = slcr_pkg::LANES,
   parameter int unsigned SETTLE = slcr_pkg::CLK_SETTLE_CYCLES
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rstn,
   // Register port
   input  wire logic [slcr_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [slcr_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output      logic [slcr_pkg::DATA_W-1:0] o_rdata_q,
   // Sync pins, active low, asynchronous to i_clk
   input  wire logic                        i_single_ended_sync_input_n,
   input  wire logic                        i_timestamp_input_pair_n,
   // Decoded output mode from the mode table, same clock
   input  wire logic                        i_mode_uses_64b66b,
   input  wire logic [slcr_pkg::LCNT_W-1:0] i_mode_lane_count,
   input  wire logic [slcr_pkg::E_W-1:0]    i_mode_e,
   input  wire logic [slcr_pkg::F_W-1:0]    i_mode_f,
   // Settings toward the link
   output      logic [slcr_pkg::MODE_W-1:0] o_link_output_mode_q,
   output      logic [slcr_pkg::TEST_W-1:0] o_link_test_control_q,
   output      logic [slcr_pkg::K_W-1:0]    o_frames_per_multiframe_q,
   output      logic                        o_sync_request_q,
   output      logic [LANES-1:0]            o_lane_enable_q,
   output      logic                        o_sample_format_q,
   output      logic                        o_whitening_active_q,
   // Link power and reset control
   output      logic                        o_link_reset_n_q,
   output      logic                        o_serdes_power_down_q,
   output      logic                        o_link_clk_enable_q,
   output      logic                        o_mf_counter_reset_q
);

   // Register fields
   logic                        link_enable_q;
   logic [slcr_pkg::MODE_W-1:0] link_output_mode_q;
   logic [slcr_pkg::KM1_W-1:0]  frames_per_multiframe_minus_one_q;
   logic                        soft_sync_request_n_q;
   logic                        upper_lane_select_q;
   logic [slcr_pkg::SSEL_W-1:0] sync_source_q;
   logic                        sample_format_q;
   logic                        whitening_enable_q;
   logic [slcr_pkg::TEST_W-1:0] link_test_control_q;

   // Filtered sync pins
   logic                        se_sync_n_q;
   logic                        ts_sync_n_q;

   // Enable sequencer
   slcr_pkg::slcr_state_e       state_q;
   slcr_pkg::slcr_state_e       state_d;
   logic [slcr_pkg::SETTLE_W-1:0] settle_q;

   // Bus decode
   logic                        wr_enable;
   logic                        wr_mode;
   logic                        wr_km1;
   logic                        wr_sync;
   logic                        wr_ctrl;
   logic                        wr_test;
   logic [slcr_pkg::DATA_W-1:0] rdata_d;
   logic [slcr_pkg::DATA_W-1:0] link_ctrl_view;

   // Derived link controls
   logic                        sync_request_d;
   logic [LANES-1:0]            lane_enable_d;
   logic                        link_running;

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   assign wr_enable = i_wr && (i_addr == slcr_pkg::ADDR_LINK_ENABLE);
   assign wr_mode   = i_wr && (i_addr == slcr_pkg::ADDR_OUTPUT_MODE);
   assign wr_km1    = i_wr && (i_addr == slcr_pkg::ADDR_FRAMES_PER_MF);
   assign wr_sync   = i_wr && (i_addr == slcr_pkg::ADDR_SOFT_SYNC);
   assign wr_ctrl   = i_wr && (i_addr == slcr_pkg::ADDR_LINK_CONTROL);
   assign wr_test   = i_wr && (i_addr == slcr_pkg::ADDR_TEST_CONTROL);

   // Reserved bits are dropped on write; they always read back as zero
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         link_enable_q <= slcr_pkg::RST_LINK_ENABLE;
      else if (wr_enable)
         link_enable_q <= i_wdata[0];
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         link_output_mode_q <= slcr_pkg::RST_OUTPUT_MODE;
      else if (wr_mode)
         link_output_mode_q <= i_wdata[slcr_pkg::MODE_W-1:0];
   end

   // The write is not blocked while the link runs; software must clear enable first
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         frames_per_multiframe_minus_one_q <= slcr_pkg::RST_KM1;
      else if (wr_km1)
         frames_per_multiframe_minus_one_q <= i_wdata;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         soft_sync_request_n_q <= slcr_pkg::RST_SOFT_SYNC_N;
      else if (wr_sync)
         soft_sync_request_n_q <= i_wdata[0];
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         whitening_enable_q  <= slcr_pkg::RST_LINK_CTRL[slcr_pkg::CTRL_WHITEN_BIT];
         sample_format_q     <= slcr_pkg::RST_LINK_CTRL[slcr_pkg::CTRL_FORMAT_BIT];
         sync_source_q       <= slcr_pkg::RST_LINK_CTRL[slcr_pkg::CTRL_SSEL_LSB +: 2];
         upper_lane_select_q <= slcr_pkg::RST_LINK_CTRL[slcr_pkg::CTRL_UPPER_BIT];
      end
      else if (wr_ctrl)
      begin
         whitening_enable_q  <= i_wdata[slcr_pkg::CTRL_WHITEN_BIT];
         sample_format_q     <= i_wdata[slcr_pkg::CTRL_FORMAT_BIT];
         sync_source_q       <= i_wdata[slcr_pkg::CTRL_SSEL_LSB +: 2];
         upper_lane_select_q <= i_wdata[slcr_pkg::CTRL_UPPER_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         link_test_control_q <= slcr_pkg::RST_TEST_CTRL;
      else if (wr_test)
         link_test_control_q <= i_wdata[slcr_pkg::TEST_W-1:0];
   end

   // ---------------------------------------------------------------
   // Read path: data stand for the one cycle after the strobe only
   // ---------------------------------------------------------------
   always_comb
   begin
      link_ctrl_view = '0;
      link_ctrl_view[slcr_pkg::CTRL_WHITEN_BIT]      = whitening_enable_q;
      link_ctrl_view[slcr_pkg::CTRL_FORMAT_BIT]      = sample_format_q;
      link_ctrl_view[slcr_pkg::CTRL_SSEL_LSB +: 2]   = sync_source_q;
      link_ctrl_view[slcr_pkg::CTRL_UPPER_BIT]       = upper_lane_select_q;
   end

   always_comb
   begin
      rdata_d = '0;
      case (i_addr)
         slcr_pkg::ADDR_LINK_ENABLE:   rdata_d = {7'h00, link_enable_q};
         slcr_pkg::ADDR_OUTPUT_MODE:   rdata_d = {2'h0, link_output_mode_q};
         slcr_pkg::ADDR_FRAMES_PER_MF: rdata_d = frames_per_multiframe_minus_one_q;
         slcr_pkg::ADDR_SOFT_SYNC:     rdata_d = {7'h00, soft_sync_request_n_q};
         slcr_pkg::ADDR_LINK_CONTROL:  rdata_d = link_ctrl_view;
         slcr_pkg::ADDR_TEST_CONTROL:  rdata_d = {3'h0, link_test_control_q};
         default:                      rdata_d = '0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rdata_q <= '0;
      else if (i_rd)
         o_rdata_q <= rdata_d;
      else
         o_rdata_q <= '0;
   end

   // ---------------------------------------------------------------
   // Sync request
   // ---------------------------------------------------------------
   slcr_pin_filter #(
      .WIDTH     (2),
      .RESET_VAL (2'h3)
   ) u_sync_pins (
      .i_clk     (i_clk),
      .i_rstn    (i_rstn),
      .i_pin     ({i_timestamp_input_pair_n, i_single_ended_sync_input_n}),
      .o_level_q ({ts_sync_n_q, se_sync_n_q})
   );

   // Software request is ORed with the selected pin; a stuck pin is escaped
   // by selecting any other source, and the reserved code also uses no pin
   always_comb
   begin
      sync_request_d = !soft_sync_request_n_q;
      case (sync_source_q)
         slcr_pkg::SSEL_SINGLE_ENDED: sync_request_d = sync_request_d || !se_sync_n_q;
         slcr_pkg::SSEL_TIMESTAMP:    sync_request_d = sync_request_d || !ts_sync_n_q;
         slcr_pkg::SSEL_SOFTWARE:     sync_request_d = sync_request_d;
         default:                     sync_request_d = sync_request_d;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_sync_request_q <= 1'b0;
      else
         o_sync_request_q <= sync_request_d;
   end

   // ---------------------------------------------------------------
   // Link enable sequencer: clocks first, then release from reset
   // ---------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         slcr_pkg::SLCR_OFF:
            if (link_enable_q)
               state_d = slcr_pkg::SLCR_CLK_ON;
         slcr_pkg::SLCR_CLK_ON:
            if (!link_enable_q)
               state_d = slcr_pkg::SLCR_OFF;
            else if (settle_q == slcr_pkg::SETTLE_W'(SETTLE - 1))
               state_d = slcr_pkg::SLCR_RUN;
         slcr_pkg::SLCR_RUN:
            if (!link_enable_q)
               state_d = slcr_pkg::SLCR_OFF;
         default:
            state_d = slcr_pkg::SLCR_OFF;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         state_q <= slcr_pkg::SLCR_OFF;
      else
         state_q <= state_d;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         settle_q <= '0;
      else if (state_q == slcr_pkg::SLCR_CLK_ON)
         settle_q <= settle_q + slcr_pkg::SETTLE_W'(1);
      else
         settle_q <= '0;
   end

   assign link_running = (state_q == slcr_pkg::SLCR_RUN);

   // Power, clock and reset controls follow the sequencer state
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_link_clk_enable_q   <= 1'b0;
         o_serdes_power_down_q <= 1'b1;
         o_link_reset_n_q      <= 1'b0;
         o_mf_counter_reset_q  <= 1'b1;
      end
      else
      begin
         o_link_clk_enable_q   <= (state_d != slcr_pkg::SLCR_OFF);
         o_serdes_power_down_q <= (state_d == slcr_pkg::SLCR_OFF);
         o_link_reset_n_q      <= (state_d == slcr_pkg::SLCR_RUN);
         o_mf_counter_reset_q  <= (state_d != slcr_pkg::SLCR_RUN);
      end
   end

   // ---------------------------------------------------------------
   // Lane mapping: one term per lane
   // ---------------------------------------------------------------
   genvar ln;
   generate
      for (ln = 0; ln < LANES; ln++)
      begin : g_lane
         localparam logic [slcr_pkg::LCNT_W:0] LANE_IDX = (slcr_pkg::LCNT_W+1)'(ln);
         localparam logic [slcr_pkg::LCNT_W:0] BASE     =
            (slcr_pkg::LCNT_W+1)'(slcr_pkg::UPPER_BASE);
         // Upper mapping with more than four lanes is left as computed
         always_comb
         begin
            if (upper_lane_select_q)
               lane_enable_d[ln] = (LANE_IDX >= BASE) &&
                  ((LANE_IDX - BASE) < {1'b0, i_mode_lane_count});
            else
               lane_enable_d[ln] = LANE_IDX < {1'b0, i_mode_lane_count};
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_lane_enable_q <= '0;
      else if (link_running)
         o_lane_enable_q <= lane_enable_d;
      else
         o_lane_enable_q <= '0;
   end

   // ---------------------------------------------------------------
   // Multiframe length, coding and pass-through settings
   // ---------------------------------------------------------------
   slcr_k_calc #(
      .KW          (slcr_pkg::K_W),
      .EW          (slcr_pkg::E_W),
      .FW          (slcr_pkg::F_W)
   ) u_k_calc (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_is_64b66b (i_mode_uses_64b66b),
      .i_km1       (frames_per_multiframe_minus_one_q),
      .i_e         (i_mode_e),
      .i_f         (i_mode_f),
      .o_k_q       (o_frames_per_multiframe_q)
   );

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_whitening_active_q <= slcr_pkg::RST_LINK_CTRL[slcr_pkg::CTRL_WHITEN_BIT];
         o_sample_format_q    <= slcr_pkg::RST_LINK_CTRL[slcr_pkg::CTRL_FORMAT_BIT];
      end
      else
      begin
         o_whitening_active_q <= i_mode_uses_64b66b || whitening_enable_q;
         o_sample_format_q    <= sample_format_q;
      end
   end

   assign o_link_output_mode_q  = link_output_mode_q;
   assign o_link_test_control_q = link_test_control_q;

endmodule

// >>> verif/slcr_rx_model.sv
// Far-end receiver model driving the active-low sync lines
`timescale 1ns/1ps
module slcr_rx_model (
   input  wire logic i_clk,
   input  wire logic i_se_req,
   input  wire logic i_ts_req,
   output      logic o_se_n,
   output      logic o_ts_n
);
   initial {o_se_n, o_ts_n} = 2'b11;
   // Both lines are actively driven, so a request lands right after a clock edge
   always @(posedge i_clk)
   begin
      o_se_n <= !i_se_req;
      o_ts_n <= !i_ts_req;
   end
endmodule

// >>> verif/slcr_serial_link_config_regs_props.sv
// Port-level checks for the serial link configuration register bank
`timescale 1ns/1ps
module slcr_serial_link_config_regs_props #(
   parameter int unsigned LANES  = 8,
   parameter int unsigned SETTLE = 4
) (
   input wire logic             i_clk,
   input wire logic             i_rstn,
   input wire logic [9:0]       i_addr,
   input wire logic [7:0]       i_wdata,
   input wire logic             i_wr,
   input wire logic             i_rd,
   input wire logic [7:0]       o_rdata_q,
   input wire logic             i_mode_uses_64b66b,
   input wire logic [3:0]       i_mode_lane_count,
   input wire logic [2:0]       i_mode_e,
   input wire logic [4:0]       i_mode_f,
   input wire logic [11:0]      o_frames_per_multiframe_q,
   input wire logic             o_sync_request_q,
   input wire logic [LANES-1:0] o_lane_enable_q,
   input wire logic             o_whitening_active_q,
   input wire logic             o_link_reset_n_q,
   input wire logic             o_serdes_power_down_q,
   input wire logic             o_link_clk_enable_q,
   input wire logic             o_mf_counter_reset_q
);
   logic [LANES-1:0] msk;
   assign msk = LANES'((1 << i_mode_lane_count) - 1);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_rd_idle; !$past(i_rd) |-> o_rdata_q == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_rd_unmapped;
      i_rd && (i_addr < 10'h200 || i_addr > 10'h205) |=> o_rdata_q == 8'h00;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("bad unmapped read");
   property p_km1;
      i_wr && i_addr == slcr_pkg::ADDR_FRAMES_PER_MF && !i_mode_uses_64b66b ##1
      !i_mode_uses_64b66b |=> o_frames_per_multiframe_q == 12'($past(i_wdata, 2)) + 12'h001;
   endproperty
   a_km1: assert property (p_km1) else $error("frames per multiframe wrong");
   property p_k66;
      i_mode_uses_64b66b && $past(i_mode_uses_64b66b) && $stable(i_mode_e) && $stable(i_mode_f)
      && $past(i_rstn) |-> o_frames_per_multiframe_q ==
      12'((256 * i_mode_e) / ((i_mode_f == 5'h00) ? 5'h01 : i_mode_f));
   endproperty
   a_k66: assert property (p_k66) else $error("64b66b multiframe length wrong");
   property p_sync_soft;
      i_wr && i_addr == slcr_pkg::ADDR_SOFT_SYNC && !i_wdata[0] |-> ##2 o_sync_request_q;
   endproperty
   a_sync_soft: assert property (p_sync_soft) else $error("soft sync missing");
   property p_en_off;
      i_wr && i_addr == slcr_pkg::ADDR_LINK_ENABLE && !i_wdata[0] |-> ##2 (!o_link_clk_enable_q
      && o_serdes_power_down_q && !o_link_reset_n_q && o_mf_counter_reset_q)
      ##1 o_lane_enable_q == '0;
   endproperty
   a_en_off: assert property (p_en_off) else $error("link not held off");
   property p_en_on;
      $rose(o_link_clk_enable_q) |-> !o_serdes_power_down_q && !o_link_reset_n_q ##SETTLE
      o_link_reset_n_q && !o_mf_counter_reset_q;
   endproperty
   a_en_on: assert property (p_en_on) else $error("link reset release timing wrong");
   property p_lanes;
      o_link_reset_n_q && $past(o_link_reset_n_q) && $stable(i_mode_lane_count) |->
      o_lane_enable_q == msk || o_lane_enable_q == LANES'(msk << 4);
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane enables wrong");
   property p_whiten66;
      i_mode_uses_64b66b && $past(i_mode_uses_64b66b) && $past(i_rstn) |-> o_whitening_active_q;
   endproperty
   a_whiten66: assert property (p_whiten66) else $error("64b66b not scrambled");
   c_soft: cover property (i_wr && i_addr == slcr_pkg::ADDR_SOFT_SYNC ##2 o_sync_request_q);
   c_upper: cover property (o_lane_enable_q == LANES'(8'hF0));
   c_k66: cover property (i_mode_uses_64b66b && o_whitening_active_q);
endmodule
bind slcr_serial_link_config_regs slcr_serial_link_config_regs_props #(.LANES(LANES),
   .SETTLE(SETTLE)) u_props (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_q,
   .i_mode_uses_64b66b, .i_mode_lane_count, .i_mode_e, .i_mode_f, .o_frames_per_multiframe_q,
   .o_sync_request_q, .o_lane_enable_q, .o_whitening_active_q, .o_link_reset_n_q,
   .o_serdes_power_down_q, .o_link_clk_enable_q, .o_mf_counter_reset_q);

// >>> verif/test_serial_link_config_regs.sv
// Self-checking bench for the serial link configuration register bank
`timescale 1ns/1ps
module test_serial_link_config_regs;
   logic       i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic       i_mode_uses_64b66b = 1'b0, se_req = 1'b0, ts_req = 1'b0;
   logic [9:0] i_addr = 10'h000;
   logic [7:0] i_wdata = 8'h00, rdata, lanes;
   logic [3:0] i_mode_lane_count = 4'h2;
   logic [2:0] i_mode_e = 3'h1;
   logic [4:0] i_mode_f = 5'h01, test;
   logic [5:0] mode;
   logic [11:0] k;
   logic       se_n, ts_n, sreq, fmt, whi, lrst_n, pd, clken, mfr;
   int         errors = 0, checked = 0, cyc = 0;
   logic [7:0] mdl [6] = '{8'h01, 8'h00, 8'h1F, 8'h01, 8'h03, 8'h00};
   logic [7:0] msk [6] = '{8'h01, 8'h3F, 8'hFF, 8'h01, 8'h1F, 8'h1F};
   slcr_rx_model rx (.i_clk, .i_se_req(se_req), .i_ts_req(ts_req), .o_se_n(se_n), .o_ts_n(ts_n));
   slcr_serial_link_config_regs uut (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata_q(rdata), .i_single_ended_sync_input_n(se_n), .i_timestamp_input_pair_n(ts_n),
      .i_mode_uses_64b66b, .i_mode_lane_count, .i_mode_e, .i_mode_f,
      .o_link_output_mode_q(mode), .o_link_test_control_q(test), .o_frames_per_multiframe_q(k),
      .o_sync_request_q(sreq), .o_lane_enable_q(lanes), .o_sample_format_q(fmt),
      .o_whitening_active_q(whi), .o_link_reset_n_q(lrst_n), .o_serdes_power_down_q(pd),
      .o_link_clk_enable_q(clken), .o_mf_counter_reset_q(mfr));
   always #25 i_clk = ~i_clk;
   // Whole run needs under 3000 cycles; the ceiling leaves ample slack
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         errors++;
         results();
      end
   end
   task chk(input string n, input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      if (a >= 10'h200 && a <= 10'h205) mdl[a[2:0]] = d & msk[a[2:0]];
   endtask
   task rd(input logic [9:0] a);
      logic [7:0] e;
      e = (a >= 10'h200 && a <= 10'h205) ? mdl[a[2:0]] : 8'h00;
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk("rdata", {4'h0, e}, {4'h0, rdata});
   endtask
   task outs();
      logic [11:0] ek;
      ek = i_mode_uses_64b66b ? 12'((256 * i_mode_e) / i_mode_f) : {4'h0, mdl[2]} + 12'h001;
      chk("k", ek, k);
      chk("format", {11'h0, mdl[4][1]}, {11'h0, fmt});
      chk("whiten", {11'h0, mdl[4][0] | i_mode_uses_64b66b}, {11'h0, whi});
      chk("mode", {6'h0, mdl[1][5:0]}, {6'h0, mode});
      chk("test", {7'h0, mdl[5][4:0]}, {7'h0, test});
   endtask
   task results();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      int a, l, up, src, ev;
      void'($urandom(84182));
      repeat (5) @(posedge i_clk);
      i_rstn <= 1'b1;
      for (a = 0; a < 7; a++) rd(10'h200 + 10'(a));
      outs();
      $display("test reset done");
      wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h00);
      for (int i = 0; i < 20; i++)
      begin
         a = 1 + $urandom % 5;
         wr(10'h200 + 10'(a), 8'($urandom) & msk[a]);
         rd(10'h200 + 10'(a));
         outs();
      end
      wr(10'h1FF, 8'hFF);
      rd(10'h1FF);
      $display("test readback done");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_clk);
         i_mode_uses_64b66b <= 1'b1;
         i_mode_e <= 3'($urandom);
         i_mode_f <= 5'(1 + $urandom % 31);
         wr(slcr_pkg::ADDR_LINK_CONTROL, mdl[4] & 8'hFE);
         wt(2);
         outs();
      end
      i_mode_uses_64b66b <= 1'b0;
      wr(slcr_pkg::ADDR_LINK_CONTROL, mdl[4] | 8'h01);
      $display("test coding done");
      // Source 1 also needs the timestamp receiver on, which lives outside this bank
      for (int c = 0; c < 24; c++)
      begin
         src = c / 8;
         wr(slcr_pkg::ADDR_LINK_CONTROL, (mdl[4] & 8'h13) | 8'(src << 2));
         wr(slcr_pkg::ADDR_SOFT_SYNC, 8'(c & 1));
         se_req <= c[1];
         ts_req <= c[2];
         wt(8);
         ev = !c[0] || (src == 0 && c[1]) || (src == 1 && c[2]);
         chk("sync", 12'(ev), {11'h0, sreq});
      end
      se_req <= 1'b0;
      ts_req <= 1'b0;
      wr(slcr_pkg::ADDR_SOFT_SYNC, 8'h01);
      $display("test sync done");
      for (int c = 0; c < 9; c++)
      begin
         l = (c == 8) ? 8 : c % 4 + 1;
         up = (c == 8) ? 0 : c / 4;
         wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h00);
         i_mode_lane_count <= 4'(l);
         wr(slcr_pkg::ADDR_LINK_CONTROL, (mdl[4] & 8'h0F) | 8'(up << 4));
         wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h01);
         wt(10);
         ev = ((1 << l) - 1) << (up * 4);
         chk("lanes", {4'hA, 8'(ev)}, {clken, pd, lrst_n, mfr, lanes});
      end
      wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h00);
      wt(3);
      chk("off", 12'h500, {clken, pd, lrst_n, mfr, lanes});
      $display("test lanes done");
      i_rstn <= 1'b0;
      mdl = '{8'h01, 8'h00, 8'h1F, 8'h01, 8'h03, 8'h00};
      wt(2);
      i_rstn <= 1'b1;
      for (a = 0; a < 6; a++) rd(10'h200 + 10'(a));
      $display("test second reset done");
      results();
   end
endmodule
